// ### csw_consts.svh
`ifndef CSW_CONSTS_SVH
`define CSW_CONSTS_SVH

`define CSW_ADDR_W 2
`define CSW_DATA_W 8
`define CSW_ADDR_CTRL 2'h0
`define CSW_ADDR_TRIM 2'h1
`define CSW_ADDR_CFG 2'h2

`define CSW_CTRL_SRC_HI 7
`define CSW_CTRL_SRC_LO 6
`define CSW_CTRL_IFS_HI 5
`define CSW_CTRL_IFS_LO 4
`define CSW_CTRL_XR_HI 3
`define CSW_CTRL_XR_LO 2
`define CSW_CTRL_EXTERNAL_CLOCK_GENERATOR_ENABLE 1
`define CSW_CTRL_ENGAGED 0
`define CSW_CFG_KEEP 1
`define CSW_CFG_CLKOUT 0

`define CSW_TRIM_RESET 8'h80
`define CSW_TRIM_CENTER 10'sd128
`define CSW_TRIM_STEP_SHIFT 9
`define CSW_EDGES_TO_ENGAGE 2'h2

`define CSW_CLK_SYS_KHZ 100000
`define CSW_INT_F4_KHZ 4000
`define CSW_INT_F8_KHZ 8000
`define CSW_INT_F12_KHZ 12800
`define CSW_ACC_STEP 17'h00100
`define CSW_HALF_Q8_F4 (`CSW_CLK_SYS_KHZ * 128 / `CSW_INT_F4_KHZ)
`define CSW_HALF_Q8_F8 (`CSW_CLK_SYS_KHZ * 128 / `CSW_INT_F8_KHZ)
`define CSW_HALF_Q8_F12 (`CSW_CLK_SYS_KHZ * 128 / `CSW_INT_F12_KHZ)

`endif

// ### csw_pkg.sv
package csw_pkg;

    typedef enum logic [1:0] {
        CSW_SRC_INT,
        CSW_SRC_EXT,
        CSW_SRC_RC,
        CSW_SRC_XTAL
    } csw_src_t;

    typedef enum logic [1:0] {
        CSW_IFS_4M,
        CSW_IFS_8M,
        CSW_IFS_12M8,
        CSW_IFS_RSVD
    } csw_ifs_t;

    typedef enum logic [1:0] {
        CSW_XR_HIGH,
        CSW_XR_MID,
        CSW_XR_LOW,
        CSW_XR_RSVD
    } csw_xr_t;

    typedef enum logic [1:0] {
        CSW_ST_INT,
        CSW_ST_CHECK,
        CSW_ST_EXT
    } csw_state_t;

    typedef struct packed {
        csw_src_t src;
        csw_ifs_t ifs;
        csw_xr_t xr;
        logic external_clock_generator_enable;
    } csw_ctrl_t;

    typedef struct packed {
        logic drive_val;
        logic oe_n;
        logic xtal_amp_out;
        logic gpio_free;
    } csw_pin_out_t;

    typedef struct packed {
        logic full_rate_en;
        logic half_rate_en;
        logic full_rate_level;
    } csw_clocks_t;

endpackage

// ### csw_int_osc.sv
`timescale 1ns/1ps
`include "csw_consts.svh"

module csw_int_osc
    import csw_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_run,
    input wire logic [15:0] i_half_q8,
    input wire logic [7:0] i_trim,
    output logic o_level,
    output logic o_rise
);

    logic signed [9:0] trim_s;
    logic signed [26:0] prod;
    logic signed [17:0] period_s;
    logic [16:0] period;
    logic [16:0] acc_reg;
    logic [16:0] acc_sum;

    // A larger trim value lengthens the half period, lowering the frequency.
    always_comb
    begin
        trim_s = $signed({2'b00, i_trim}) - `CSW_TRIM_CENTER;
        prod = trim_s * $signed({1'b0, i_half_q8});
        period_s = $signed({2'b00, i_half_q8}) + prod[26:`CSW_TRIM_STEP_SHIFT];
        period = period_s[16:0];
        acc_sum = acc_reg + `CSW_ACC_STEP;
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            acc_reg <= 17'h00000;
            o_level <= 1'b0;
            o_rise <= 1'b0;
        end
        else if (!i_run)
        begin
            acc_reg <= 17'h00000;
            o_level <= 1'b0;
            o_rise <= 1'b0;
        end
        else if (acc_sum >= period)
        begin
            acc_reg <= acc_sum - period;
            o_level <= ~o_level;
            o_rise <= ~o_level;
        end
        else
        begin
            acc_reg <= acc_sum;
            o_rise <= 1'b0;
        end
    end

endmodule

// ### csw_ext_sync.sv
`timescale 1ns/1ps

module csw_ext_sync
    import csw_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_pin,
    output logic o_level,
    output logic o_rise
);

    logic meta_reg;
    logic last_reg;

    // Two flip-flops bring the pin into the clock domain before any logic reads it.
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            meta_reg <= 1'b0;
            o_level <= 1'b0;
            last_reg <= 1'b0;
            o_rise <= 1'b0;
        end
        else
        begin
            meta_reg <= i_pin;
            o_level <= meta_reg;
            last_reg <= o_level;
            o_rise <= o_level & ~last_reg;
        end
    end

endmodule

// ### csw_top.sv
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "csw_consts.svh"

module csw_top
    import csw_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic [`CSW_ADDR_W-1:0] i_addr,
    input wire logic [`CSW_DATA_W-1:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_stop_osc_enable,
    input wire logic i_osc_input_pin,
    output logic [`CSW_DATA_W-1:0] o_rd_data,
    output csw_clocks_t o_clocks,
    output csw_pin_out_t o_osc_output_pin,
    output logic o_osc_input_pin_en,
    output logic [2:0] o_crystal_amp_en,
    output logic o_int_osc_running,
    output logic o_irq
);

    // ************************************************************
    // Decoding helpers.
    // ************************************************************

    function automatic logic [2:0] xtal_amp_decode(input csw_src_t src, input csw_xr_t xr);
        logic [2:0] amp;
        amp = 3'h0;
        if (src == CSW_SRC_XTAL)
        begin
            case (xr)
                CSW_XR_HIGH: amp = 3'h1;
                CSW_XR_MID: amp = 3'h2;
                CSW_XR_LOW: amp = 3'h4;
                default: amp = 3'h0;
            endcase
        end
        return amp;
    endfunction

    function automatic logic [15:0] half_period_decode(input csw_ifs_t ifs);
        logic [15:0] hp;
        hp = 16'(`CSW_HALF_Q8_F4);
        case (ifs)
            CSW_IFS_8M: hp = 16'(`CSW_HALF_Q8_F8);
            CSW_IFS_12M8: hp = 16'(`CSW_HALF_Q8_F12);
            default: hp = 16'(`CSW_HALF_Q8_F4);
        endcase
        return hp;
    endfunction

    // ************************************************************
    // Reset release.
    // ************************************************************

    logic rst_meta_reg;
    logic rst_n_sync;

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rst_meta_reg <= 1'b0;
            rst_n_sync <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n_sync <= rst_meta_reg;
        end
    end

    // ************************************************************
    // Declarations.
    // ************************************************************

    csw_ctrl_t ctrl_reg;
    logic [7:0] trim_reg;
    logic keep_alive_reg;
    logic clkout_en_reg;
    csw_state_t state_reg;
    logic engaged_reg;
    logic int_run_reg;
    logic [1:0] edge_cnt_reg;
    logic half_phase_reg;
    logic osc_on;
    logic ext_req;
    logic wr_ctrl;
    logic wr_trim;
    logic wr_cfg;
    logic int_level;
    logic int_rise;
    logic ext_level;
    logic ext_rise;
    logic sel_rise;
    logic sel_level;

    assign wr_ctrl = i_wr && (i_addr == `CSW_ADDR_CTRL);
    assign wr_trim = i_wr && (i_addr == `CSW_ADDR_TRIM);
    assign wr_cfg = i_wr && (i_addr == `CSW_ADDR_CFG);
    assign osc_on = i_stop_osc_enable | keep_alive_reg;
    assign ext_req = ctrl_reg.external_clock_generator_enable && (ctrl_reg.src != CSW_SRC_INT);

    // ************************************************************
    // Control register.
    // ************************************************************

    always_ff @(posedge i_clk_sys or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            ctrl_reg.src <= CSW_SRC_INT;
            ctrl_reg.ifs <= CSW_IFS_4M;
            ctrl_reg.xr <= CSW_XR_HIGH;
            ctrl_reg.external_clock_generator_enable <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            ctrl_reg.src <= csw_src_t'(i_wr_data[`CSW_CTRL_SRC_HI:`CSW_CTRL_SRC_LO]);
            ctrl_reg.ifs <= csw_ifs_t'(i_wr_data[`CSW_CTRL_IFS_HI:`CSW_CTRL_IFS_LO]);
            ctrl_reg.xr <= csw_xr_t'(i_wr_data[`CSW_CTRL_XR_HI:`CSW_CTRL_XR_LO]);
            ctrl_reg.external_clock_generator_enable <= i_wr_data[`CSW_CTRL_EXTERNAL_CLOCK_GENERATOR_ENABLE];
        end
    end

    // ************************************************************
    // Trim register, reset to the centre; never loaded by hardware.
    // ************************************************************

    always_ff @(posedge i_clk_sys or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            trim_reg <= `CSW_TRIM_RESET;
        end
        else if (wr_trim)
        begin
            trim_reg <= i_wr_data;
        end
    end

    // ************************************************************
    // Configuration register.
    // ************************************************************

    always_ff @(posedge i_clk_sys or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            keep_alive_reg <= 1'b0;
            clkout_en_reg <= 1'b0;
        end
        else
        begin
            if (wr_cfg)
            begin
                keep_alive_reg <= i_wr_data[`CSW_CFG_KEEP];
            end
            if (ctrl_reg.src == CSW_SRC_EXT)
            begin
                clkout_en_reg <= 1'b0;
            end
            else if (wr_cfg)
            begin
                clkout_en_reg <= i_wr_data[`CSW_CFG_CLKOUT];
            end
        end
    end

    // ************************************************************
    // Read port.
    // ************************************************************

    always_ff @(posedge i_clk_sys or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            o_rd_data <= 8'h00;
        end
        else if (i_rd)
        begin
            case (i_addr)
                `CSW_ADDR_CTRL: o_rd_data <= {ctrl_reg, engaged_reg};
                `CSW_ADDR_TRIM: o_rd_data <= trim_reg;
                `CSW_ADDR_CFG: o_rd_data <= {6'h00, keep_alive_reg, clkout_en_reg};
                default: o_rd_data <= 8'h00;
            endcase
        end
        else
        begin
            o_rd_data <= 8'h00;
        end
    end

    // ************************************************************
    // Clock sources.
    // ************************************************************

    csw_int_osc u_int_osc (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(rst_n_sync),
        .i_run(int_run_reg & osc_on),
        .i_half_q8(half_period_decode(ctrl_reg.ifs)),
        .i_trim(trim_reg),
        .o_level(int_level),
        .o_rise(int_rise)
    );

    csw_ext_sync u_ext_sync (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(rst_n_sync),
        .i_pin(i_osc_input_pin),
        .o_level(ext_level),
        .o_rise(ext_rise)
    );

    // ************************************************************
    // Source hand-over.
    // ************************************************************

    always_ff @(posedge i_clk_sys or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            state_reg <= CSW_ST_INT;
            engaged_reg <= 1'b0;
            int_run_reg <= 1'b1;
            edge_cnt_reg <= 2'h0;
        end
        else
        begin
            case (state_reg)
                CSW_ST_INT:
                begin
                    int_run_reg <= 1'b1;
                    engaged_reg <= 1'b0;
                    edge_cnt_reg <= 2'h0;
                    if (ext_req)
                    begin
                        state_reg <= CSW_ST_CHECK;
                    end
                end
                CSW_ST_CHECK:
                begin
                    if (!ext_req)
                    begin
                        state_reg <= CSW_ST_INT;
                    end
                    else if (ext_rise && osc_on)
                    begin
                        edge_cnt_reg <= edge_cnt_reg + 2'h1;
                        if (edge_cnt_reg + 2'h1 == `CSW_EDGES_TO_ENGAGE)
                        begin
                            engaged_reg <= 1'b1;
                            state_reg <= CSW_ST_EXT;
                        end
                    end
                end
                CSW_ST_EXT:
                begin
                    if (!ext_req)
                    begin
                        engaged_reg <= 1'b0;
                        int_run_reg <= 1'b1;
                        state_reg <= CSW_ST_INT;
                    end
                    else
                    begin
                        int_run_reg <= 1'b0;
                    end
                end
                default:
                begin
                    state_reg <= CSW_ST_INT;
                end
            endcase
        end
    end

    // ************************************************************
    // Full-rate and half-rate clocks; wait mode has no effect here.
    // ************************************************************

    assign sel_rise = (engaged_reg ? ext_rise : int_rise) & osc_on;
    assign sel_level = engaged_reg ? ext_level : int_level;

    always_ff @(posedge i_clk_sys or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            o_clocks <= '0;
            half_phase_reg <= 1'b0;
        end
        else
        begin
            o_clocks.full_rate_en <= sel_rise;
            o_clocks.full_rate_level <= sel_level & osc_on;
            if (sel_rise)
            begin
                half_phase_reg <= ~half_phase_reg;
            end
            o_clocks.half_rate_en <= sel_rise & half_phase_reg;
        end
    end

    // ************************************************************
    // Oscillator pins.
    // ************************************************************

    always_ff @(posedge i_clk_sys or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            o_osc_input_pin_en <= 1'b0;
            o_crystal_amp_en <= 3'h0;
            o_osc_output_pin <= '{drive_val: 1'b0, oe_n: 1'b1, xtal_amp_out: 1'b0,
                                  gpio_free: 1'b1};
        end
        else
        begin
            o_osc_input_pin_en <= (ctrl_reg.src != CSW_SRC_INT) && osc_on;
            o_crystal_amp_en <= osc_on ? xtal_amp_decode(ctrl_reg.src, ctrl_reg.xr) : 3'h0;
            case (ctrl_reg.src)
                CSW_SRC_XTAL:
                begin
                    o_osc_output_pin.drive_val <= 1'b0;
                    o_osc_output_pin.oe_n <= 1'b1;
                    o_osc_output_pin.xtal_amp_out <= 1'b1;
                    o_osc_output_pin.gpio_free <= 1'b0;
                end
                CSW_SRC_EXT:
                begin
                    o_osc_output_pin.drive_val <= 1'b0;
                    o_osc_output_pin.oe_n <= 1'b1;
                    o_osc_output_pin.xtal_amp_out <= 1'b0;
                    o_osc_output_pin.gpio_free <= 1'b1;
                end
                default:
                begin
                    o_osc_output_pin.drive_val <= clkout_en_reg & sel_level & osc_on;
                    o_osc_output_pin.oe_n <= ~clkout_en_reg;
                    o_osc_output_pin.xtal_amp_out <= 1'b0;
                    o_osc_output_pin.gpio_free <= ~clkout_en_reg;
                end
            endcase
        end
    end

    // ************************************************************
    // Status outputs.
    // ************************************************************

    always_ff @(posedge i_clk_sys or negedge rst_n_sync)
    begin
        if (!rst_n_sync)
        begin
            o_int_osc_running <= 1'b0;
            o_irq <= 1'b0;
        end
        else
        begin
            o_int_osc_running <= int_run_reg & osc_on;
            o_irq <= 1'b0;
        end
    end

endmodule

// ### csw_chk.sv
`timescale 1ns/1ps
`include "csw_consts.svh"

module csw_chk
    import csw_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic [`CSW_ADDR_W-1:0] i_addr,
    input wire logic [`CSW_DATA_W-1:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_stop_osc_enable,
    input wire logic i_osc_input_pin,
    input wire logic [`CSW_DATA_W-1:0] o_rd_data,
    input wire csw_clocks_t o_clocks,
    input wire csw_pin_out_t o_osc_output_pin,
    input wire logic o_osc_input_pin_en,
    input wire logic [2:0] o_crystal_amp_en,
    input wire logic o_int_osc_running,
    input wire logic o_irq
);
    // ****************************************
    // Shadow registers and checks.
    // ****************************************
    logic [7:0] ctrl_reg;
    logic [1:0] cfg_reg;
    logic half_seen_reg;
    logic [1:0] src;
    logic [2:0] amp_exp;
    assign src = ctrl_reg[7:6];
    assign amp_exp = (ctrl_reg[3:2] == 2'h3) ? 3'h0 : 3'(3'h1 << ctrl_reg[3:2]);
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            ctrl_reg <= 8'h00;
        else if (i_wr && i_addr == `CSW_ADDR_CTRL)
            ctrl_reg <= i_wr_data;
    end
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            cfg_reg <= 2'h0;
        else
        begin
            if (i_wr && i_addr == `CSW_ADDR_CFG)
                cfg_reg <= i_wr_data[1:0];
            if (src == CSW_SRC_EXT)
                cfg_reg[0] <= 1'b0;
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            half_seen_reg <= 1'b1;
        else if (o_clocks.full_rate_en)
            half_seen_reg <= o_clocks.half_rate_en;
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    a_irq_never: assert property (!o_irq)
        else $error("interrupt raised");
    a_half_in_full: assert property (o_clocks.half_rate_en |-> o_clocks.full_rate_en)
        else $error("half pulse without full pulse");
    a_half_alternate: assert property (o_clocks.full_rate_en |->
        o_clocks.half_rate_en != half_seen_reg) else $error("half pulse not every second");
    a_stop_halts: assert property ((!i_stop_osc_enable && !cfg_reg[1])[*3] |->
        !o_clocks.full_rate_en && !o_int_osc_running && !o_osc_input_pin_en)
        else $error("clocks run in stop");
    a_int_restart: assert property ((src == CSW_SRC_INT && i_stop_osc_enable)[*5] |->
        o_int_osc_running) else $error("internal oscillator not running");
    a_int_stop_cause: assert property ($fell(o_int_osc_running) && $past(i_stop_osc_enable)
        |-> src != CSW_SRC_INT && ctrl_reg[1]) else $error("internal stop without hand-over");
    a_input_pin_on: assert property ((src != CSW_SRC_INT && i_stop_osc_enable)[*2] |->
        o_osc_input_pin_en) else $error("input pin not enabled");
    a_amp_match: assert property ((src == CSW_SRC_XTAL && i_stop_osc_enable
        && $stable(ctrl_reg))[*2] |-> o_crystal_amp_en == amp_exp && o_osc_output_pin.xtal_amp_out)
        else $error("crystal amplifier mismatch");
    a_ext_no_out: assert property ((src == CSW_SRC_EXT)[*2] |->
        o_osc_output_pin.oe_n && o_osc_output_pin.gpio_free) else $error("pin driven in ext");
    a_clk_out_on: assert property (((src == CSW_SRC_INT || src == CSW_SRC_RC) && cfg_reg[0])[*2]
        |-> !o_osc_output_pin.oe_n) else $error("clock out not driven");
    a_rc_gpio: assert property ((src == CSW_SRC_RC && !cfg_reg[0])[*2] |->
        o_osc_output_pin.oe_n && o_osc_output_pin.gpio_free) else $error("rc pin not free");
endmodule

bind csw_top csw_chk csw_chk_inst (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr(i_wr), .i_rd(i_rd), .i_stop_osc_enable(i_stop_osc_enable),
    .i_osc_input_pin(i_osc_input_pin), .o_rd_data(o_rd_data), .o_clocks(o_clocks),
    .o_osc_output_pin(o_osc_output_pin), .o_osc_input_pin_en(o_osc_input_pin_en),
    .o_crystal_amp_en(o_crystal_amp_en), .o_int_osc_running(o_int_osc_running),
    .o_irq(o_irq)
);

// ### csw_sys_model.sv
`timescale 1ns/1ps

module csw_sys_model
    import csw_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire csw_clocks_t i_clocks,
    input wire logic i_stop_req,
    input wire logic i_clr,
    output logic o_stop_osc_enable,
    output logic [15:0] o_n_full,
    output logic [15:0] o_n_half,
    output logic [15:0] o_n_bus
);
    // ****************************************
    // Stop enable and bus clock divider.
    // ****************************************
    logic bus_phase_reg;
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_stop_osc_enable <= 1'b1;
        else
            o_stop_osc_enable <= !i_stop_req;
    end
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n || i_clr)
        begin
            o_n_full <= 16'h0000;
            o_n_half <= 16'h0000;
            o_n_bus <= 16'h0000;
            bus_phase_reg <= 1'b0;
        end
        else
        begin
            o_n_full <= o_n_full + 16'(i_clocks.full_rate_en);
            o_n_half <= o_n_half + 16'(i_clocks.half_rate_en);
            if (i_clocks.half_rate_en)
                bus_phase_reg <= !bus_phase_reg;
            if (i_clocks.half_rate_en && bus_phase_reg)
                o_n_bus <= o_n_bus + 16'h0001;
        end
    end
endmodule

// ### csw_top_tb_top.sv
`timescale 1ns/1ps

module csw_top_tb_top
    import csw_pkg::*;
;
    // ****************************************
    // Bench signals, design and partner.
    // ****************************************
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic pin = 1'b0;
    logic ext_run = 1'b0;
    logic stop_req = 1'b0;
    logic clr = 1'b0;
    logic stop_en;
    logic [7:0] rd_data;
    csw_clocks_t clocks;
    csw_pin_out_t pin_out;
    logic pin_en;
    logic [2:0] amp_en;
    logic int_run;
    logic irq;
    logic [15:0] n_full;
    logic [15:0] n_half;
    logic [15:0] n_bus;
    int num_errors = 0;
    int n_checks = 0;
    int exp_f[4] = '{40, 80, 128, 40};
    always #5 clk = !clk;
    always
    begin
        repeat (4) @(posedge clk);
        pin <= ext_run ? !pin : 1'b0;
    end
    csw_top csw_top_inst (.i_clk_sys(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wr_data(wdata),
        .i_wr(wr_s), .i_rd(rd_s), .i_stop_osc_enable(stop_en), .i_osc_input_pin(pin),
        .o_rd_data(rd_data), .o_clocks(clocks), .o_osc_output_pin(pin_out),
        .o_osc_input_pin_en(pin_en), .o_crystal_amp_en(amp_en),
        .o_int_osc_running(int_run), .o_irq(irq));
    csw_sys_model csw_sys_model_inst (.i_clk_sys(clk), .i_rst_n(rst_n), .i_clocks(clocks),
        .i_stop_req(stop_req), .i_clr(clr), .o_stop_osc_enable(stop_en),
        .o_n_full(n_full), .o_n_half(n_half), .o_n_bus(n_bus));
    // ****************************************
    // Shared tasks.
    // ****************************************
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic near(input logic [15:0] got, input int exp, input string msg);
        n_checks++;
        if ($isunknown(got) || got + 2 < exp || got > exp + 2)
        begin
            num_errors++;
            $display("MISMATCH %0t %s got %0d exp %0d", $time, msg, got, exp);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rdc(input logic [1:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        check(16'(rd_data), 16'(e), "read");
    endtask
    task automatic measure(input int n);
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask
    // ****************************************
    // Scenarios.
    // ****************************************
    task automatic t_reset;
        rdc(2'h0, 8'h00);
        rdc(2'h1, 8'h80);
        rdc(2'h2, 8'h00);
        rdc(2'h3, 8'h00);
        measure(1000);
        near(n_full, 40, "reset freq");
        check(16'(irq), 16'h0, "irq");
        $display("test reset done");
    endtask
    task automatic t_freq;
        for (int i = 0; i < 4; i++)
        begin
            wr(2'h0, 8'(i << 4));
            rdc(2'h0, 8'(i << 4));
            measure(1000);
            near(n_full, exp_f[i], "full");
            near(n_half, exp_f[i] / 2, "half");
            near(n_bus, exp_f[i] / 4, "bus");
        end
        wr(2'h0, 8'h00);
        $display("test freq done");
    endtask
    task automatic t_trim;
        wr(2'h1, 8'h00);
        rdc(2'h1, 8'h00);
        measure(1000);
        near(n_full, 53, "trim low");
        wr(2'h1, 8'hFF);
        measure(1000);
        near(n_full, 32, "trim high");
        wr(2'h1, 8'h80);
        $display("test trim done");
    endtask
    task automatic t_stop;
        @(posedge clk);
        stop_req <= 1'b1;
        measure(300);
        check(n_full, 16'h0, "stop pulses");
        check(16'(int_run), 16'h0, "stop osc");
        wr(2'h2, 8'h02);
        rdc(2'h2, 8'h02);
        measure(1000);
        near(n_full, 40, "keep alive");
        @(posedge clk);
        stop_req <= 1'b0;
        wr(2'h2, 8'h00);
        $display("test stop done");
    endtask
    task automatic t_ext;
        wr(2'h0, 8'h40);
        repeat (20) @(posedge clk);
        wr(2'h0, 8'h42);
        rdc(2'h0, 8'h42);
        measure(200);
        near(n_full, 8, "no edges");
        ext_run <= 1'b1;
        repeat (40) @(posedge clk);
        rdc(2'h0, 8'h43);
        check(16'(int_run), 16'h0, "int stopped");
        check(16'(pin_en), 16'h1, "pin en");
        measure(800);
        near(n_full, 100, "ext full");
        near(n_half, 50, "ext half");
        wr(2'h2, 8'h01);
        rdc(2'h2, 8'h00);
        check(16'(pin_out.oe_n), 16'h1, "ext oe");
        wr(2'h0, 8'h00);
        ext_run <= 1'b0;
        repeat (10) @(posedge clk);
        rdc(2'h0, 8'h00);
        check(16'(int_run), 16'h1, "int back");
        measure(1000);
        near(n_full, 40, "int back freq");
        $display("test ext done");
    endtask
    task automatic t_pins;
        int ones = 0;
        int lvl = 0;
        wr(2'h0, 8'h80);
        settle;
        check(16'({pin_out.oe_n, pin_out.gpio_free}), 16'h3, "rc gpio");
        wr(2'h2, 8'h01);
        settle;
        check(16'(pin_out.oe_n), 16'h0, "rc out");
        for (int x = 0; x < 4; x++)
        begin
            wr(2'h0, 8'hC0 | 8'(x << 2));
            settle;
            check(16'(amp_en), (x == 3) ? 16'h0 : 16'(1 << x), "amp");
            check(16'(pin_out.xtal_amp_out), 16'h1, "xtal pin");
        end
        wr(2'h0, 8'h00);
        settle;
        check(16'(pin_out.oe_n), 16'h0, "int out");
        check(16'(pin_en), 16'h0, "int pin en");
        repeat (25)
        begin
            @(posedge clk);
            #1;
            ones += pin_out.drive_val;
            lvl += clocks.full_rate_level;
        end
        near(16'(ones), 12, "clock out duty");
        near(16'(lvl), 12, "clock level duty");
        wr(2'h2, 8'h00);
        $display("test pins done");
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        #300000;
        num_errors++;
        $display("MISMATCH %0t watchdog expired", $time);
        print_verdict;
    end
    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        t_reset;
        t_freq;
        t_trim;
        t_stop;
        t_ext;
        t_pins;
        print_verdict;
    end
endmodule
